// ===== rtl/sbw_pkg.sv
// types shared by the byte-lane write masking block
// assumes nothing of its surroundings
package sbw_pkg;

  // operation decoded at a true-clock rise
  typedef enum logic [1:0] {
    OP_NOP   = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10
  } op_t;

endpackage

// ===== rtl/sbw_regs.svh
// constants for the burst sram byte-lane write masking block
// assumes inclusion by bare name from the design files; definitions only
`ifndef SBW_REGS_SVH
`define SBW_REGS_SVH

`define SBW_LANE_W   9
`define SBW_LANES    4
`define SBW_ADDR_W   19
`define SBW_WORD0    1'b0
`define SBW_WORD1    1'b1
`define SBW_OE_RST   1'b0
// system cycles after reset before clock rises count; covers the two sync stages
`define SBW_WARM     2'h3

`endif

// ===== rtl/sbw_sync.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes the bundle bits are independent levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sbw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ===== rtl/sram_byte_write_masking.sv
// burst sram core with byte-lane masked double-rate writes
// assumes true and complementary clocks far slower than clk_sys_i,
// so their synchronised rises never land in the same system cycle,
// and every pin held steady for three system cycles around each rise;
// the array itself has no reset, so unwritten words read back unknown;
// read data leaves two and a half clock cycles after its load
`timescale 1ns/1ps
`default_nettype none
`include "sbw_regs.svh"

module sram_byte_write_masking #(
  parameter int LANES  = `SBW_LANES,
  parameter int ADDR_W = `SBW_ADDR_W,
  parameter int DW     = LANES * `SBW_LANE_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              k_i,
  input  wire logic              k_n_i,
  input  wire logic              load_strobe_n_i,
  input  wire logic              read_write_sel_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DW-1:0]     dq_i,
  input  wire logic [LANES-1:0]  byte_lane_select_n_i,
  output logic      [DW-1:0]     dq_o,
  output logic                   dq_oe_o
);

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  localparam int SW = 4 + ADDR_W + DW + LANES;

  logic [SW-1:0]     pins_async;
  logic [SW-1:0]     pins_sync;
  logic              s_k;
  logic              s_kn;
  logic              s_ld_n;
  logic              s_rw;
  logic [ADDR_W-1:0] s_addr;
  logic [DW-1:0]     s_dq;
  logic [LANES-1:0]  s_sel_n;

  // everything shares one delay, so data stays aligned to its clock edge
  assign pins_async = {k_i, k_n_i, load_strobe_n_i, read_write_sel_i, addr_i, dq_i, byte_lane_select_n_i};

  sbw_sync #(
    .W (SW)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pins_async),
    .sync_o    (pins_sync)
  );

  assign {s_k, s_kn, s_ld_n, s_rw, s_addr, s_dq, s_sel_n} = pins_sync;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // expand active-low lane selects into a bit mask, one lane per 9 bits
  function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i*`SBW_LANE_W +: `SBW_LANE_W] = {`SBW_LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction

  // decode the operation presented at a true-clock rise
  function automatic sbw_pkg::op_t decode_op(input logic ld_n, input logic rw);
    if (ld_n) begin
      return sbw_pkg::OP_NOP;
    end else if (rw) begin
      return sbw_pkg::OP_READ;
    end
    return sbw_pkg::OP_WRITE;
  endfunction

  // word index within the array: the burst address picks the pair,
  // the flag picks the first or second word of it
  function automatic logic [ADDR_W:0] word_idx(input logic [ADDR_W-1:0] a, input logic second);
    return {a, second};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic              k_d;
    logic              kn_d;
    logic [1:0]        warm;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_pend_addr;
    logic              wr_act;
    logic [ADDR_W-1:0] wr_act_addr;
    logic              rd1;
    logic [ADDR_W-1:0] rd1_addr;
    logic              rd2;
    logic [ADDR_W-1:0] rd2_addr;
    logic              rd3;
    logic [ADDR_W-1:0] rd3_addr;
    logic              rd_second;
    logic [ADDR_W-1:0] rd_second_addr;
    logic [DW-1:0]     dq;
    logic              oe;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [DW-1:0]     mem [0:(2**(ADDR_W+1))-1];
  logic              armed;
  logic              k_rise;
  logic              kn_rise;
  sbw_pkg::op_t      op;
  logic              we;
  logic [ADDR_W:0]   waddr;
  logic [DW-1:0]     wmask;
  logic [ADDR_W:0]   raddr;
  logic [DW-1:0]     rword;

  // edge detection on synchronised clocks; held off just after reset, since the
  // cleared synchroniser would otherwise turn a parked-high clock into a false rise
  assign armed   = (st_r.warm == `SBW_WARM);
  assign k_rise  = s_k & ~st_r.k_d & armed;
  assign kn_rise = s_kn & ~st_r.kn_d & armed;
  assign op      = k_rise ? decode_op(s_ld_n, s_rw) : sbw_pkg::OP_NOP;

  // ------------------------------------------------------------
  // array write port
  // ------------------------------------------------------------
  // one port is enough since the two data edges never coincide
  always_comb begin
    we    = 1'b0;
    waddr = '0;
    wmask = lane_mask(s_sel_n);
    if (k_rise && st_r.wr_pend) begin
      we    = 1'b1;
      waddr = word_idx(st_r.wr_pend_addr, `SBW_WORD0);
    end else if (kn_rise && st_r.wr_act) begin
      we    = 1'b1;
      waddr = word_idx(st_r.wr_act_addr, `SBW_WORD1);
    end
  end

  // unselected lanes keep stored bits; an all-high pattern writes nothing
  always_ff @(posedge clk_sys_i) begin
    if (we && (|wmask)) begin
      mem[waddr] <= (mem[waddr] & ~wmask) | (s_dq & wmask);
    end
  end

  // read address: first word at a complementary rise, second at a true rise
  assign raddr = kn_rise ? word_idx(st_r.rd3_addr, `SBW_WORD0) : word_idx(st_r.rd_second_addr, `SBW_WORD1);
  assign rword = mem[raddr];

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  // no read-after-write bypass: the controller must leave a gap between them
  always_comb begin
    st_nxt      = st_r;
    st_nxt.k_d  = s_k;
    st_nxt.kn_d = s_kn;
    // warm-up count saturates once the synchroniser holds real pin levels
    if (st_r.warm != `SBW_WARM) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end
    if (k_rise) begin
      // write pipeline: load, then word 0 next rise, word 1 at following low rise
      st_nxt.wr_act       = st_r.wr_pend;
      st_nxt.wr_act_addr  = st_r.wr_pend_addr;
      st_nxt.wr_pend      = (op == sbw_pkg::OP_WRITE);
      st_nxt.wr_pend_addr = s_addr;
      // read pipeline: load at rise t, first word at the complementary rise after t+2
      // a read loaded at each true rise keeps the pipe full back to back
      st_nxt.rd1      = (op == sbw_pkg::OP_READ);
      st_nxt.rd1_addr = s_addr;
      st_nxt.rd2      = st_r.rd1;
      st_nxt.rd2_addr = st_r.rd1_addr;
      st_nxt.rd3      = st_r.rd2;
      st_nxt.rd3_addr = st_r.rd2_addr;
      if (st_r.rd_second) begin
        st_nxt.dq        = rword;
        st_nxt.rd_second = 1'b0;
      end
    end
    if (kn_rise) begin
      st_nxt.wr_act = 1'b0;
      if (st_r.rd3) begin
        st_nxt.dq             = rword;
        st_nxt.oe             = 1'b1;
        st_nxt.rd_second      = 1'b1;
        st_nxt.rd_second_addr = st_r.rd3_addr;
      end else begin
        st_nxt.oe = 1'b0;
      end
    end
  end

  // state register; comes up deselected with outputs released
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r    <= '0;
      st_r.oe <= `SBW_OE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // straight from the state register so the pins see no logic glitches
  assign dq_o    = st_r.dq;
  assign dq_oe_o = st_r.oe;

endmodule

`default_nettype wire

// ===== testbench/ctrl_model.sv
// controller model driving the sram pins in slow double-rate phases
// assumes clk_sys_i far faster than the pin clocks
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic        clk_sys_i,
  input  wire logic [35:0] q_i,
  input  wire logic        oe_i,
  output logic             k_o,
  output logic             k_n_o,
  output logic             load_strobe_n_o,
  output logic             read_write_sel_o,
  output logic [18:0]      addr_o,
  output logic [35:0]      dq_o,
  output logic [3:0]       byte_lane_select_n_o
);
  // both clocks parked high between frames for the quickest restart; every lane selected
  initial begin
    {k_o, k_n_o, load_strobe_n_o, read_write_sel_o} = 4'hE;
    {addr_o, dq_o, byte_lane_select_n_o} = '0;
  end
  // half clock: pins move mid-phase so they hold around each rise
  task automatic ph(input logic kv, ld, rw, input logic [18:0] a, input logic [35:0] d, input logic [3:0] s);
    @(posedge clk_sys_i);
    {load_strobe_n_o, read_write_sel_o, addr_o, dq_o, byte_lane_select_n_o} <= {ld, rw, a, d, s};
    repeat (4) @(posedge clk_sys_i);
    {k_o, k_n_o} <= {kv, !kv};
    repeat (7) @(posedge clk_sys_i);
  endtask
  // park both clocks high; the true clock rises here with load high, a no-op
  task automatic park;
    @(posedge clk_sys_i);
    {k_o, k_n_o} <= 2'h3;
    repeat (11) @(posedge clk_sys_i);
  endtask
  // idle pins show inverted values, never a stale copy
  task automatic wr(input logic [18:0] a, input logic [35:0] d0, d1, input logic [3:0] s0, s1);
    ph(0, 1, 0, ~a, ~dq_o, '1); // leave the parked level, no rise
    ph(1, 0, 0, a, ~dq_o, '1);
    ph(0, 1, 0, ~a, ~dq_o, '1);
    ph(1, 1, 0, ~a, d0, s0);
    ph(0, 1, 0, ~a, d1, s1);
    park();
  endtask
  task automatic rd(input logic [18:0] a, output logic [35:0] q0, q1, output logic oe);
    ph(0, 1, 0, ~a, ~dq_o, '1);
    ph(1, 0, 1, a, ~dq_o, '1);
    repeat (5) ph(!k_o, 1, 0, ~a, ~dq_o, '1);
    q0 = q_i;
    ph(1, 1, 0, ~a, ~dq_o, '1);
    q1 = q_i;
    ph(0, 1, 0, ~a, ~dq_o, '1);
    oe = oe_i;
    park();
  endtask
endmodule
`default_nettype wire

// ===== testbench/sbw_chk.sv
// pin assertions for the masked-write sram
// bound into sram_byte_write_masking at the foot
`timescale 1ns/1ps
`default_nettype none
module sbw_chk #(parameter int DW = 36) (
  input wire logic          clk_sys_i,
  input wire logic          sys_rst_i,
  input wire logic          k_i,
  input wire logic          k_n_i,
  input wire logic          load_strobe_n_i,
  input wire logic [DW-1:0] dq_o,
  input wire logic          dq_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] idle_r;
  // cycles since last load, saturating so long idles stay flagged
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) idle_r <= '0;
    else idle_r <= !load_strobe_n_i ? '0 : idle_r + 8'(idle_r != 8'hFF);
  end
  a_reset_clear: assert property (disable iff (1'b0) sys_rst_i |-> !dq_oe_o && dq_o == '0)
    else $error("outputs not cleared");
  a_release_quiet: assert property ($fell(sys_rst_i) |-> !dq_oe_o [*2])
    else $error("driving after reset");
  a_oe_on_kn: assert property ($rose(dq_oe_o) |-> k_n_i && !$past(k_n_i, 8))
    else $error("drive start off k_n");
  a_oe_off_kn: assert property ($fell(dq_oe_o) |-> k_n_i && !$past(k_n_i, 8))
    else $error("release off k_n");
  a_dq_on_edge: assert property ($changed(dq_o) |-> k_i != $past(k_i, 8))
    else $error("data moved off a clock rise");
  a_dq_stands: assert property ($changed(dq_o) |=> $stable(dq_o) [*3])
    else $error("data glitch");
  a_oe_stands: assert property ($rose(dq_oe_o) |=> dq_oe_o [*3])
    else $error("enable glitch");
  a_idle_off: assert property (idle_r == 8'hFF |-> !dq_oe_o)
    else $error("driving while idle");
  c_drive: cover property ($rose(dq_oe_o));
  c_release: cover property ($fell(dq_oe_o));
  c_load: cover property (k_i && !load_strobe_n_i);
endmodule
bind sram_byte_write_masking sbw_chk #(.DW(DW)) sbw_chk_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .k_i(k_i), .k_n_i(k_n_i), .load_strobe_n_i(load_strobe_n_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the masked-write sram, four lanes and a two-lane variant
// assumes ctrl_model on the pins and sbw_chk bound in
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [18:0] a;
    logic [3:0]  s0, s1;
    logic [35:0] e0, e1;
  } row_t;
  logic clk_sys_i = 0;
  logic sys_rst_i = 0;
  logic k, k_n, ld_n, rw, oe, oe_seen;
  logic [18:0] addr;
  logic [35:0] dq, q, q0, q1;
  logic [3:0] sel;
  logic        use18 = 1'b0;
  logic        oe18, oem;
  logic [17:0] q18;
  logic [35:0] qm;
  int failures = 0;
  int comparisons = 0;
  // each row: full background, then two differing lane patterns
  row_t rows [4] = '{
    '{19'h00000, 4'h0, 4'hF, 36'hFFFFFFFFF, 36'h000000000},
    '{19'h00001, 4'hE, 4'hD, 36'h0000001FF, 36'h00003FE00},
    '{19'h40000, 4'hB, 4'h7, 36'h007FC0000, 36'hFF8000000},
    '{19'h7FFFF, 4'hF, 4'h0, 36'h000000000, 36'hFFFFFFFFF}};
  sram_byte_write_masking sram_byte_write_masking_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .k_i(k), .k_n_i(k_n), .load_strobe_n_i(ld_n), .read_write_sel_i(rw), .addr_i(addr), .dq_i(dq),
    .byte_lane_select_n_i(sel), .dq_o(q), .dq_oe_o(oe));
  // narrow two-lane variant on the low half of the same pins
  sram_byte_write_masking #(.LANES(2)) sram_byte_write_masking_x18_i (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .k_i(k), .k_n_i(k_n), .load_strobe_n_i(ld_n), .read_write_sel_i(rw),
    .addr_i(addr), .dq_i(dq[17:0]), .byte_lane_select_n_i(sel[1:0]), .dq_o(q18), .dq_oe_o(oe18));
  // the model reads back whichever variant is under test
  assign qm  = use18 ? {18'h00000, q18} : q;
  assign oem = use18 ? oe18 : oe;
  ctrl_model ctrl_model_i (.clk_sys_i(clk_sys_i), .q_i(qm), .oe_i(oem), .k_o(k), .k_n_o(k_n),
    .load_strobe_n_o(ld_n), .read_write_sel_o(rw), .addr_o(addr), .dq_o(dq), .byte_lane_select_n_o(sel));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string n, input logic [35:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // run needs about 2000 cycles; cut off well beyond
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  // reset, table of lane patterns on both widths, neighbour reread, mid-run reset
  initial begin
    #1 sys_rst_i = 1;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    repeat (3) @(posedge clk_sys_i);
    chk("dq_oe_o", '0, 36'(oe));
    foreach (rows[i]) begin
      ctrl_model_i.wr(rows[i].a, '0, '0, '0, '0);
      ctrl_model_i.wr(rows[i].a, '1, '1, rows[i].s0, rows[i].s1);
      ctrl_model_i.rd(rows[i].a, q0, q1, oe_seen);
      chk("word0", rows[i].e0, q0);
      chk("word1", rows[i].e1, q1);
      chk("dq_oe_o", '0, 36'(oe_seen));
      // narrow variant: lanes 1..0 map alike, so the low 18 bits must match
      use18 <= 1'b1;
      ctrl_model_i.rd(rows[i].a, q0, q1, oe_seen);
      chk("word0_x18", {18'h00000, rows[i].e0[17:0]}, q0);
      chk("word1_x18", {18'h00000, rows[i].e1[17:0]}, q1);
      chk("dq_oe_x18", '0, 36'(oe_seen));
      use18 <= 1'b0;
    end
    ctrl_model_i.rd(19'h00000, q0, q1, oe_seen);
    chk("reread0", rows[0].e0, q0);
    chk("reread1", rows[0].e1, q1);
    // mid-run reset with data standing on the outputs; the array keeps its words
    ctrl_model_i.rd(rows[3].a, q0, q1, oe_seen);
    chk("reread3", rows[3].e1, q1);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("dq_o_in_reset", '0, q);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("dq_oe_after_reset", '0, 36'(oe));
    ctrl_model_i.rd(rows[1].a, q0, q1, oe_seen);
    chk("word0_after_reset", rows[1].e0, q0);
    chk("word1_after_reset", rows[1].e1, q1);
    finish_test();
  end
endmodule
`default_nettype wire
